// ===== pefu_pkg.sv
// Constants, field positions and types of the PLL event flag unit.
// What this block does
// - Bits 7, 6, 5 mask PLL1 lock, input and calibration; reset 0.
// - Bits 4, 3, 2 mask PLL2 lock, input and calibration; reset 0.
// - Mask bits 1 and 0 block PLL1 and PLL2 reference switch; reset zero.
// - A source whose mask bit is one never drives the combined interrupt.
// - Polarity bit one: a rising source edge sets its sticky flag.
// - Polarity bit zero: a falling edge sets the flag; resets to zero.
// - One polarity bit per source, in the same bit order as the mask.
// - A qualifying edge sets the flag bit in the mask bit order.
// - Flags capture edges only while the global enable is one.
// - Writing zero to a set flag clears it until a new edge.
// - Live source status stays readable whatever the enable says.
// - Combine 0: any unmasked flag fires; 1: all unmasked needed.
// - With the global enable at zero the interrupt output stays low.
package pefu_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int         PEFU_AW             = 8;
  localparam int         PEFU_DW             = 8;
  localparam int         PEFU_NSRC           = 8;
  localparam logic [7:0] PEFU_LIVE_ADDR      = 8'h0D;
  localparam logic [7:0] PEFU_MASK_ADDR      = 8'h0E;
  localparam logic [7:0] PEFU_POL_ADDR       = 8'h0F;
  localparam logic [7:0] PEFU_FLAG_ADDR      = 8'h10;
  localparam logic [7:0] PEFU_CTL_ADDR       = 8'h11;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PEFU_MASK_RST       = 8'h00;
  localparam logic [7:0] PEFU_POL_RST        = 8'h00;
  localparam logic [7:0] PEFU_FLAG_RST       = 8'h00;
  localparam logic       PEFU_EN_RST         = 1'h0;
  localparam logic       PEFU_COMB_RST       = 1'h0;
  localparam logic [7:0] PEFU_ZERO           = 8'h00;

  // ---------------------------------------------------------------
  // Field positions, shared by mask, polarity, flag and live registers, then control register bits
  // ---------------------------------------------------------------
  localparam int PEFU_PLL1_LOCK_LOST   = 7;
  localparam int PEFU_PLL1_INPUT_LOST  = 6;
  localparam int PEFU_PLL1_CALIBRATING = 5;
  localparam int PEFU_PLL2_LOCK_LOST   = 4;
  localparam int PEFU_PLL2_INPUT_LOST  = 3;
  localparam int PEFU_PLL2_CALIBRATING = 2;
  localparam int PEFU_PLL1_REF_SWITCH  = 1;
  localparam int PEFU_PLL2_REF_SWITCH  = 0;
  localparam int PEFU_CTL_COMB_BIT     = 1;
  localparam int PEFU_CTL_EN_BIT       = 0;

  // Combine modes of the interrupt output.
  typedef enum logic
  {
    PEFU_COMB_OR  = 1'h0,
    PEFU_COMB_AND = 1'h1
  } pefu_comb_type;

endpackage : pefu_pkg

// ===== pefu_evt_if.sv
// Interface joining the event core, edge detector and interrupt combiner.
`timescale 1ns/100ps
interface pefu_evt_if;
  import pefu_pkg::*;

  logic [PEFU_NSRC-1:0] live;      // Synchronised source levels.
  logic [PEFU_NSRC-1:0] edge_hit;  // Qualifying edge, one cycle.
  logic [PEFU_NSRC-1:0] polarity;  // Edge select per source.
  logic [PEFU_NSRC-1:0] flags;     // Sticky flags.
  logic [PEFU_NSRC-1:0] mask;      // Source blocks.
  pefu_comb_type        comb;      // OR or AND combining.
  logic                 enable;    // Global interrupt enable.
  logic                 irq_req;   // Combined request.

  modport detect  (input polarity, output live, output edge_hit);
  modport combine (input flags, input mask, input comb, input enable,
                   output irq_req);
  modport core    (output polarity, output flags, output mask,
                   output comb, output enable,
                   input live, input edge_hit, input irq_req);
endinterface : pefu_evt_if

// ===== pefu_edge_detect.sv
// Per-source synchroniser and polarity-selected edge detector.
`timescale 1ns/100ps
module pefu_edge_detect
  import pefu_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [PEFU_NSRC-1:0] src_in,
  pefu_evt_if.detect                evt
);

  typedef struct packed
  {
    logic [PEFU_NSRC-1:0] meta;
    logic [PEFU_NSRC-1:0] sync;
    logic [PEFU_NSRC-1:0] prev;
  } pefu_det_type;

  pefu_det_type det_ff;
  pefu_det_type nxt_det;

  // Shifts sources through the synchroniser and keeps last cycle's level.
  always_comb
  begin
    nxt_det      = det_ff;
    nxt_det.meta = src_in;
    nxt_det.sync = det_ff.meta;
    nxt_det.prev = det_ff.sync;
  end

  // Registers the detector state.
  always_ff @(posedge clock)
  begin
    if (rst)
      det_ff <= '0;
    else
      det_ff <= nxt_det;
  end

  // Live level for status reads.
  assign evt.live = det_ff.sync;

  // One comparator per source picks rising or falling edges.
  genvar i;
  generate
    for (i = 0; i < PEFU_NSRC; i++)
    begin : g_edge
      assign evt.edge_hit[i] = evt.polarity[i] ?
        (det_ff.sync[i] & ~det_ff.prev[i]) :
        (~det_ff.sync[i] & det_ff.prev[i]);
    end
  endgenerate

endmodule : pefu_edge_detect

// ===== pefu_irq_combine.sv
// Masked OR or AND combination of the sticky flags into one request.
`timescale 1ns/100ps
module pefu_irq_combine
  import pefu_pkg::*;
(
  pefu_evt_if.combine evt
);

  logic [PEFU_NSRC-1:0] open_src;
  logic                 any_hit;
  logic                 all_hit;

  // Unmasked flags only; an all-masked set never fires in either mode.
  always_comb
  begin
    open_src = ~evt.mask;
    any_hit  = |(evt.flags & open_src);
    all_hit  = (|open_src) & ((evt.flags & open_src) == open_src);
    if (!evt.enable)
      evt.irq_req = 1'h0;
    else if (evt.comb == PEFU_COMB_AND)
      evt.irq_req = all_hit;
    else
      evt.irq_req = any_hit;
  end

endmodule : pefu_irq_combine

// ===== pefu_flag_unit.sv
// Top of the PLL event flag unit: registers, sticky flags and interrupt.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module pefu_flag_unit
  import pefu_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [PEFU_AW-1:0]   reg_addr,
  input  wire logic [PEFU_DW-1:0]   reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output      logic [PEFU_DW-1:0]   reg_rdata,
  input  wire logic                 pll1_lock_lost,
  input  wire logic                 pll1_input_lost,
  input  wire logic                 pll1_vco_calibrating,
  input  wire logic                 pll2_lock_lost,
  input  wire logic                 pll2_input_lost,
  input  wire logic                 pll2_vco_calibrating,
  input  wire logic                 pll1_ref_back_to_primary,
  input  wire logic                 pll2_ref_back_to_primary,
  output      logic                 event_irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  typedef struct packed
  {
    logic [PEFU_NSRC-1:0] mask;
    logic [PEFU_NSRC-1:0] polarity;
    logic [PEFU_NSRC-1:0] flags;
    logic                 enable;
    pefu_comb_type        comb;
    logic [PEFU_DW-1:0]   rdata;
    logic                 irq;
  } pefu_core_type;

  pefu_core_type        core_ff;
  pefu_core_type        nxt_core;
  logic [PEFU_NSRC-1:0] src_vec;
  logic [PEFU_NSRC-1:0] clr_req;
  logic [PEFU_NSRC-1:0] set_req;
  logic [PEFU_DW-1:0]   rd_mux;
  logic                 wr_mask;
  logic                 wr_pol;
  logic                 wr_flag;
  logic                 wr_ctl;

  pefu_evt_if evt ();

  // ---------------------------------------------------------------
  // Source ordering
  // ---------------------------------------------------------------

  // Sources sit in the same bit order as the mask, polarity, flag and live registers.
  always_comb
  begin
    src_vec                        = '0;
    src_vec[PEFU_PLL1_LOCK_LOST]   = pll1_lock_lost;
    src_vec[PEFU_PLL1_INPUT_LOST]  = pll1_input_lost;
    src_vec[PEFU_PLL1_CALIBRATING] = pll1_vco_calibrating;
    src_vec[PEFU_PLL2_LOCK_LOST]   = pll2_lock_lost;
    src_vec[PEFU_PLL2_INPUT_LOST]  = pll2_input_lost;
    src_vec[PEFU_PLL2_CALIBRATING] = pll2_vco_calibrating;
    src_vec[PEFU_PLL1_REF_SWITCH]  = pll1_ref_back_to_primary;
    src_vec[PEFU_PLL2_REF_SWITCH]  = pll2_ref_back_to_primary;
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------

  // Synchronises sources and finds edges of the chosen polarity.
  pefu_edge_detect u_detect
  (
    .clock  (clock),
    .rst    (rst),
    .src_in (src_vec),
    .evt    (evt.detect)
  );

  // Folds the unmasked flags into one request.
  pefu_irq_combine u_combine
  (
    .evt (evt.combine)
  );

  // Control state handed to the submodules.
  assign evt.polarity = core_ff.polarity;
  assign evt.flags    = core_ff.flags;
  assign evt.mask     = core_ff.mask;
  assign evt.comb     = core_ff.comb;
  assign evt.enable   = core_ff.enable;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------

  // Write strobes per register.
  assign wr_mask = reg_wr && (reg_addr == PEFU_MASK_ADDR);
  assign wr_pol  = reg_wr && (reg_addr == PEFU_POL_ADDR);
  assign wr_flag = reg_wr && (reg_addr == PEFU_FLAG_ADDR);
  assign wr_ctl  = reg_wr && (reg_addr == PEFU_CTL_ADDR);

  // Read multiplexer; unmapped addresses and reserved bits read zero.
  always_comb
  begin
    rd_mux = PEFU_ZERO;
    unique case (reg_addr)
      PEFU_LIVE_ADDR: rd_mux = evt.live;
      PEFU_MASK_ADDR: rd_mux = core_ff.mask;
      PEFU_POL_ADDR:  rd_mux = core_ff.polarity;
      PEFU_FLAG_ADDR: rd_mux = core_ff.flags;
      PEFU_CTL_ADDR:
      begin
        rd_mux[PEFU_CTL_COMB_BIT] = core_ff.comb;
        rd_mux[PEFU_CTL_EN_BIT]   = core_ff.enable;
      end
      default:        rd_mux = PEFU_ZERO;
    endcase
  end

  // ---------------------------------------------------------------
  // Flag set and clear terms
  // ---------------------------------------------------------------

  // A written zero clears; a written one leaves the flag alone.
  assign clr_req = wr_flag ? ~reg_wdata : '0;

  // Edges are recorded only while the global enable is on.
  assign set_req = core_ff.enable ? evt.edge_hit : '0;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Register writes, sticky flags, read data and interrupt output.
  always_comb
  begin
    nxt_core = core_ff;
    if (wr_mask)
      nxt_core.mask = reg_wdata;
    if (wr_pol)
      nxt_core.polarity = reg_wdata;
    if (wr_ctl)
    begin
      nxt_core.comb   = pefu_comb_type'(reg_wdata[PEFU_CTL_COMB_BIT]);
      nxt_core.enable = reg_wdata[PEFU_CTL_EN_BIT];
    end
    // Set wins over a clear in the same cycle.
    nxt_core.flags = (core_ff.flags & ~clr_req)
                     | set_req;
    // Read data stand only in the cycle after the read strobe.
    nxt_core.rdata = reg_rd ? rd_mux : PEFU_ZERO;
    nxt_core.irq   = evt.irq_req;
  end

  // Registers the core state; every control bit resets to zero.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_ff          <= '0;
      core_ff.mask     <= PEFU_MASK_RST;
      core_ff.polarity <= PEFU_POL_RST;
      core_ff.flags    <= PEFU_FLAG_RST;
      core_ff.enable   <= PEFU_EN_RST;
      core_ff.comb     <= pefu_comb_type'(PEFU_COMB_RST);
    end
    else
      core_ff <= nxt_core;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Both outputs come straight from flip-flops.
  assign reg_rdata = core_ff.rdata;
  assign event_irq = core_ff.irq;

endmodule : pefu_flag_unit

// ===== pefu_flag_unit_properties.sv
// Port-level checker of the PLL event flag unit.
`timescale 1ns/100ps
module pefu_flag_unit_properties
  import pefu_pkg::*;
(
  input wire logic         clock,
  input wire logic         rst,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [7:0]   reg_rdata,
  input wire logic         pll1_lock_lost,
  input wire logic         pll1_input_lost,
  input wire logic         pll1_vco_calibrating,
  input wire logic         pll2_lock_lost,
  input wire logic         pll2_input_lost,
  input wire logic         pll2_vco_calibrating,
  input wire logic         pll1_ref_back_to_primary,
  input wire logic         pll2_ref_back_to_primary,
  input wire logic         event_irq
);
  logic [7:0] src;
  logic [7:0] mask_ff;
  logic [7:0] pol_ff;
  logic [1:0] ctl_ff;

  // Source levels gathered in register bit order.
  assign src = {pll1_lock_lost, pll1_input_lost, pll1_vco_calibrating,
                pll2_lock_lost, pll2_input_lost, pll2_vco_calibrating,
                pll1_ref_back_to_primary, pll2_ref_back_to_primary};

  // Shadows of the mask, polarity and control registers, fed by the bus writes.
  always_ff @(posedge clock)
    if (rst) mask_ff <= 8'h00;
    else if (reg_wr && reg_addr == PEFU_MASK_ADDR) mask_ff <= reg_wdata;
  always_ff @(posedge clock)
    if (rst) pol_ff <= 8'h00;
    else if (reg_wr && reg_addr == PEFU_POL_ADDR) pol_ff <= reg_wdata;
  always_ff @(posedge clock)
    if (rst) ctl_ff <= 2'h0;
    else if (reg_wr && reg_addr == PEFU_CTL_ADDR) ctl_ff <= reg_wdata[1:0];

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read slot");
  a_unmapped_read: assert property (reg_rd && (reg_addr < PEFU_LIVE_ADDR
    || reg_addr > PEFU_CTL_ADDR) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mask_readback: assert property (
    reg_rd && reg_addr == PEFU_MASK_ADDR |=> reg_rdata == $past(mask_ff))
    else $error("mask read differs from last write");
  a_pol_readback: assert property (
    reg_rd && reg_addr == PEFU_POL_ADDR |=> reg_rdata == $past(pol_ff))
    else $error("polarity read differs from last write");
  a_live_read: assert property (
    $stable(src)[*3] ##0 (reg_rd && reg_addr == PEFU_LIVE_ADDR)
    |=> reg_rdata == $past(src))
    else $error("live status read differs from sources");
  a_irq_disabled: assert property (
    (!ctl_ff[0])[*3] |-> !event_irq)
    else $error("interrupt while disabled");
  a_mask_quiet: assert property (
    (mask_ff == 8'hFF)[*3] |-> !event_irq)
    else $error("interrupt with every source masked");
  a_irq_latency: assert property (
    $rose(pll1_lock_lost) && ctl_ff == 2'h1 && pol_ff[7]
    && mask_ff == 8'h7F |-> ##4 event_irq)
    else $error("rising edge did not raise the interrupt");
endmodule : pefu_flag_unit_properties

bind pefu_flag_unit pefu_flag_unit_properties pefu_flag_unit_properties_inst
(
  .clock                    (clock),
  .rst                      (rst),
  .reg_addr                 (reg_addr),
  .reg_wdata                (reg_wdata),
  .reg_wr                   (reg_wr),
  .reg_rd                   (reg_rd),
  .reg_rdata                (reg_rdata),
  .pll1_lock_lost           (pll1_lock_lost),
  .pll1_input_lost          (pll1_input_lost),
  .pll1_vco_calibrating     (pll1_vco_calibrating),
  .pll2_lock_lost           (pll2_lock_lost),
  .pll2_input_lost          (pll2_input_lost),
  .pll2_vco_calibrating     (pll2_vco_calibrating),
  .pll1_ref_back_to_primary (pll1_ref_back_to_primary),
  .pll2_ref_back_to_primary (pll2_ref_back_to_primary),
  .event_irq                (event_irq)
);

// ===== pefu_flag_unit_tb_top.sv
// Self-checking testbench of the PLL event flag unit.
`timescale 1ns/100ps
module pefu_flag_unit_tb_top
  import pefu_pkg::*;
;
  logic       clock, rst, reg_wr, reg_rd, event_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, src;
  int         fail_count, checked;

  pefu_flag_unit pefu_flag_unit_inst
  (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pll1_lock_lost(src[7]), .pll1_input_lost(src[6]),
    .pll1_vco_calibrating(src[5]), .pll2_lock_lost(src[4]),
    .pll2_input_lost(src[3]), .pll2_vco_calibrating(src[2]),
    .pll1_ref_back_to_primary(src[1]), .pll2_ref_back_to_primary(src[0]),
    .event_irq(event_irq)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask : wr

  // Read one register and compare the data of the following cycle.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask : rdc

  task automatic irq(input int n, input logic exp);
    repeat (n) @(posedge clock);
    #1 check({7'h00, event_irq}, {7'h00, exp});
  endtask : irq

  task automatic t_reset();
    rdc(PEFU_MASK_ADDR, 8'h00);
    rdc(PEFU_POL_ADDR, 8'h00);
    rdc(PEFU_FLAG_ADDR, 8'h00);
    rdc(PEFU_CTL_ADDR, 8'h00);
    irq(0, 1'h0);
    rdc(8'h20, 8'h00);
  endtask : t_reset

  task automatic t_regs();
    wr(PEFU_MASK_ADDR, 8'hA5);
    rdc(PEFU_MASK_ADDR, 8'hA5);
    wr(PEFU_POL_ADDR, 8'h5A);
    rdc(PEFU_POL_ADDR, 8'h5A);
    wr(PEFU_LIVE_ADDR, 8'hFF);
    rdc(PEFU_LIVE_ADDR, 8'h0F);
    wr(PEFU_CTL_ADDR, 8'hFF);
    rdc(PEFU_CTL_ADDR, 8'h03);
  endtask : t_regs

  // Upper sources rise on rising polarity, lower fall on falling polarity.
  task automatic t_edges();
    wr(PEFU_POL_ADDR, 8'hF0);
    wr(PEFU_MASK_ADDR, 8'h7F);
    wr(PEFU_CTL_ADDR, 8'h01);
    @(posedge clock);
    src <= 8'hF0;
    repeat (4) @(posedge clock);
    rdc(PEFU_FLAG_ADDR, 8'hFF);
    rdc(PEFU_LIVE_ADDR, 8'hF0);
    irq(0, 1'h1);
    wr(PEFU_FLAG_ADDR, 8'h0F);
    rdc(PEFU_FLAG_ADDR, 8'h0F);
    irq(1, 1'h0);
    @(posedge clock);
    src <= 8'h0F;
    repeat (4) @(posedge clock);
    rdc(PEFU_FLAG_ADDR, 8'h0F);
  endtask : t_edges

  // Flags 0F stand; walk the mask through OR and AND combining.
  task automatic t_mask();
    wr(PEFU_MASK_ADDR, 8'h0E);
    irq(2, 1'h1);
    wr(PEFU_CTL_ADDR, 8'h03);
    irq(2, 1'h0);
    wr(PEFU_MASK_ADDR, 8'hF0);
    irq(2, 1'h1);
    wr(PEFU_MASK_ADDR, 8'hFF);
    irq(2, 1'h0);
    wr(PEFU_MASK_ADDR, 8'hF0);
  endtask : t_mask

  task automatic t_enable();
    wr(PEFU_CTL_ADDR, 8'h02);
    irq(2, 1'h0);
    wr(PEFU_FLAG_ADDR, 8'h00);
    rdc(PEFU_FLAG_ADDR, 8'h00);
    @(posedge clock);
    src <= 8'hF0;
    repeat (4) @(posedge clock);
    rdc(PEFU_FLAG_ADDR, 8'h00);
    rdc(PEFU_LIVE_ADDR, 8'hF0);
  endtask : t_enable

  // A clearing write lands on the edge that sets the flag.
  task automatic t_race();
    wr(PEFU_CTL_ADDR, 8'h01);
    @(posedge clock);
    src <= 8'h00;
    repeat (4) @(posedge clock);
    rdc(PEFU_FLAG_ADDR, 8'h00);
    @(posedge clock);
    src <= 8'h80;
    @(posedge clock);
    wr(PEFU_FLAG_ADDR, 8'h00);
    rdc(PEFU_FLAG_ADDR, 8'h80);
    wr(PEFU_FLAG_ADDR, 8'h00);
    rdc(PEFU_FLAG_ADDR, 8'h00);
  endtask : t_race

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Free-running 40 MHz clock.
  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (3000) @(posedge clock);
    fail_count++;
    end_sim();
  end

  // Main sequence: reset, then every scenario in turn.
  initial
  begin
    rst        = 1'h1;
    reg_wr     = 1'h0;
    reg_rd     = 1'h0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    src        = 8'h0F;
    fail_count = 0;
    checked    = 0;
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    t_reset();
    t_regs();
    t_edges();
    t_mask();
    t_enable();
    t_race();
    end_sim();
  end
endmodule : pefu_flag_unit_tb_top
